// file: src/boot_loader_pkg.sv
// Purpose: Shared constants for boot selection and the serial loader
// Assumes: 16-bit program space, 8N1 serial framing
// Notes: Characters are ASCII codes
package boot_loader_pkg;
  localparam logic [15:0] RESET_START = 16'h0000;
  localparam logic [15:0] BOOT_ROM_BASE = 16'hfc00;
  localparam logic [15:0] BLOCK_8K_SPLIT = 16'h2000;
  localparam logic [15:0] BLOCK_16K_BASE = 16'h4000;
  localparam int BLOCK_16K_SHIFT = 14;
  localparam logic [2:0] BLOCK_LAST = 3'h4;
  localparam logic [7:0] VECTOR_LOW = 8'h00;
  localparam logic [7:0] DEFAULT_VECTOR = 8'hfc;
  localparam logic [7:0] MAX_DATA = 8'h10;
  localparam logic [4:0] HEADER_BYTES = 5'h04;
  localparam logic [7:0] CHR_U = 8'h55;
  localparam logic [7:0] CHR_COLON = 8'h3a;
  localparam logic [7:0] CHR_LF = 8'h0a;
  localparam logic [7:0] CHR_X = 8'h58;
  localparam logic [7:0] CHR_DOT = 8'h2e;
  localparam logic [7:0] CHR_R = 8'h52;
  localparam logic [7:0] REC_DATA = 8'h00;
  localparam logic [7:0] REC_EOF = 8'h01;
  localparam logic [7:0] REC_OSC = 8'h02;
  localparam logic [7:0] REC_WRITE = 8'h03;
  localparam logic [7:0] REC_DISPLAY = 8'h04;
  localparam logic [7:0] SUB_ERASE_NV = 8'h04;
  localparam logic [7:0] SUB_PROG_NV = 8'h06;
  localparam logic [7:0] SUB_CHIP_ERASE = 8'h07;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [3:0] DATA_BITS = 4'h8;
  typedef enum logic [2:0] {R_BAUD, R_MEAS, R_SKIP, R_IDLE, R_START, R_BITS} rx_state_t;
  typedef enum logic [2:0] {P_COLON, P_HI, P_LO, P_EOL, P_EXEC, P_PROG} parse_state_t;
endpackage : boot_loader_pkg

// file: src/flash_boot_loader.sv
// Purpose: Boot start selection, flash block decode and serial hex loader
// Assumes: rxd and straps synchronous to mclk; flash store outside
// Notes: Programming bytes leave through a FIFO with valid/ready
`timescale 1ns/1ns
`default_nettype none

module loader_fifo #(parameter int WIDTH = 24, parameter int DEPTH = 32) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
    logic ov;
    logic [WIDTH-1:0] od;
  } fifo_state_t;
  fifo_state_t r_reg, r_next;
  logic push, pop;
  assign in_ready = r_reg.count != (AW+1)'(DEPTH);
  assign out_valid = r_reg.ov;
  assign out_data = r_reg.od;
  always_comb begin
    r_next = r_reg;
    push = in_valid && in_ready;
    pop = (r_reg.count != '0) && (!r_reg.ov || out_ready);
    if (push) begin
      r_next.mem[r_reg.wr] = in_data;
      r_next.wr = r_reg.wr + 1'b1;
    end
    if (out_ready) begin
      r_next.ov = 1'b0;
    end
    if (pop) begin
      r_next.od = r_reg.mem[r_reg.rd];
      r_next.ov = 1'b1;
      r_next.rd = r_reg.rd + 1'b1;
    end
    r_next.count = r_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule : loader_fifo

module flash_boot_loader #(parameter int CW = 16, parameter int DEPTH = 32) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic rxd,
  output logic txd,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] boot_vector,
  input wire logic program_store_strobe_n,
  input wire logic port2_bit7_strap,
  input wire logic external_access_n,
  input wire logic ale_strap,
  output logic [15:0] start_addr,
  output logic start_valid,
  input wire logic boot_rom_enable,
  input wire logic [15:0] fetch_addr,
  output logic fetch_boot_rom,
  output logic [2:0] fetch_block,
  output logic prog_valid,
  input wire logic prog_ready,
  input wire logic prog_fail,
  output logic [15:0] prog_addr,
  output logic [7:0] prog_data,
  output logic [7:0] osc_mhz,
  output logic nv_write,
  output logic [7:0] nv_status,
  output logic [7:0] nv_vector,
  output logic cmd_valid,
  output logic [7:0] cmd_type,
  output logic [7:0] cmd_sub,
  output logic [7:0] cmd_sel,
  output logic baud_locked
);
  typedef struct packed {
    boot_loader_pkg::rx_state_t rx_st;
    logic [CW-1:0] rx_cnt;
    logic [CW-1:0] bit_len;
    logic [3:0] rx_bits;
    logic [7:0] rx_shift;
    logic [9:0] tx_shift;
    logic [3:0] tx_bits;
    logic [CW-1:0] tx_cnt;
    logic tx_busy;
    logic txd;
    logic echo_pend;
    logic [7:0] echo_ch;
    logic rep_pend;
    logic [7:0] rep_ch;
    boot_loader_pkg::parse_state_t ps;
    logic [3:0] nib;
    logic [4:0] idx;
    logic [7:0] sum;
    logic [7:0] cnt;
    logic [7:0] typ;
    logic [15:0] addr;
    logic [15:0][7:0] data;
    logic [4:0] push_i;
    logic [4:0] done_i;
    logic fail;
    logic boot_done;
    logic [15:0] start_addr;
    logic start_valid;
    logic fetch_rom;
    logic [2:0] fetch_block;
    logic [7:0] osc;
    logic nv_write;
    logic [7:0] nv_status;
    logic [7:0] nv_vector;
    logic cmd_valid;
    logic locked;
  } state_t;
  state_t r_reg, r_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic fifo_in_valid, fifo_in_ready, strap_force;

  function automatic logic [4:0] hexval(input logic [7:0] c);
    if (c >= "0" && c <= "9") hexval = {1'b1, 4'(c - "0")};
    else if (c >= "A" && c <= "F") hexval = {1'b1, 4'(c - "A" + 8'h0a)};
    else if (c >= "a" && c <= "f") hexval = {1'b1, 4'(c - "a" + 8'h0a)};
    else hexval = 5'h00;
  endfunction : hexval

  function automatic logic [2:0] block_of(input logic [15:0] a);
    if (a < boot_loader_pkg::BLOCK_16K_BASE) block_of = (a < boot_loader_pkg::BLOCK_8K_SPLIT) ? 3'h0 : 3'h1;
    else block_of = 3'(a >> boot_loader_pkg::BLOCK_16K_SHIFT) + 3'h1;
  endfunction : block_of

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign strap_force = !program_store_strobe_n && port2_bit7_strap && external_access_n && ale_strap;

  loader_fifo #(.WIDTH(24), .DEPTH(DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({r_reg.addr + 16'(r_reg.push_i), r_reg.data[r_reg.push_i[3:0]]}),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data({prog_addr, prog_data})
  );

  always_comb begin
    logic got;
    logic [7:0] ch;
    logic [4:0] h;
    logic [7:0] b;
    got = 1'b0;
    ch = r_reg.rx_shift;
    h = 5'h00;
    b = 8'h00;
    r_next = r_reg;
    r_next.nv_write = 1'b0;
    r_next.cmd_valid = 1'b0;
    fifo_in_valid = 1'b0;
    // Boot start selection at reset release
    if (!r_reg.boot_done) begin
      r_next.boot_done = 1'b1;
      r_next.start_valid = 1'b1;
      if (status_byte == 8'h00 && !strap_force) r_next.start_addr = boot_loader_pkg::RESET_START;
      else r_next.start_addr = {boot_vector, boot_loader_pkg::VECTOR_LOW};
    end
    r_next.fetch_rom = boot_rom_enable && fetch_addr >= boot_loader_pkg::BOOT_ROM_BASE;
    r_next.fetch_block = block_of(fetch_addr);
    // Receiver with baud measurement
    case (r_reg.rx_st)
      boot_loader_pkg::R_BAUD: begin
        if (!rxd) begin
          r_next.rx_st = boot_loader_pkg::R_MEAS;
          r_next.rx_cnt = CW'(1);
        end
      end
      boot_loader_pkg::R_MEAS: begin
        if (rxd) begin
          r_next.bit_len = r_reg.rx_cnt;
          r_next.rx_cnt = '0;
          r_next.rx_st = boot_loader_pkg::R_SKIP;
          got = 1'b1;
          ch = boot_loader_pkg::CHR_U;
        end else begin
          r_next.rx_cnt = r_reg.rx_cnt + 1'b1;
        end
      end
      boot_loader_pkg::R_SKIP: begin
        r_next.rx_cnt = rxd ? r_reg.rx_cnt + 1'b1 : '0;
        if ((CW+1)'(r_reg.rx_cnt) >= {r_reg.bit_len, 1'b0}) r_next.rx_st = boot_loader_pkg::R_IDLE;
      end
      boot_loader_pkg::R_IDLE: begin
        r_next.rx_cnt = '0;
        if (!rxd) r_next.rx_st = boot_loader_pkg::R_START;
      end
      boot_loader_pkg::R_START: begin
        r_next.rx_cnt = r_reg.rx_cnt + 1'b1;
        if (r_reg.rx_cnt == (r_reg.bit_len >> 1)) begin
          r_next.rx_cnt = '0;
          r_next.rx_bits = '0;
          r_next.rx_st = rxd ? boot_loader_pkg::R_IDLE : boot_loader_pkg::R_BITS;
        end
      end
      boot_loader_pkg::R_BITS: begin
        r_next.rx_cnt = r_reg.rx_cnt + 1'b1;
        if (r_reg.rx_cnt == r_reg.bit_len - 1'b1) begin
          r_next.rx_cnt = '0;
          if (r_reg.rx_bits == boot_loader_pkg::DATA_BITS) begin
            got = 1'b1;
            r_next.rx_st = boot_loader_pkg::R_IDLE;
          end else begin
            r_next.rx_shift = {rxd, r_reg.rx_shift[7:1]};
            r_next.rx_bits = r_reg.rx_bits + 1'b1;
          end
        end
      end
      default: r_next.rx_st = boot_loader_pkg::R_BAUD;
    endcase
    r_next.locked = r_next.rx_st != boot_loader_pkg::R_BAUD && r_next.rx_st != boot_loader_pkg::R_MEAS;
    // Transmitter: echo first, then reply
    if (!r_reg.tx_busy) begin
      if (r_reg.echo_pend || r_reg.rep_pend) begin
        r_next.tx_shift = {1'b1, r_reg.echo_pend ? r_reg.echo_ch : r_reg.rep_ch, 1'b0};
        r_next.tx_busy = 1'b1;
        r_next.tx_bits = '0;
        r_next.tx_cnt = '0;
        if (r_reg.echo_pend) r_next.echo_pend = 1'b0;
        else r_next.rep_pend = 1'b0;
      end
    end else begin
      r_next.tx_cnt = r_reg.tx_cnt + 1'b1;
      if (r_reg.tx_cnt == r_reg.bit_len - 1'b1) begin
        r_next.tx_cnt = '0;
        r_next.tx_shift = {1'b1, r_reg.tx_shift[9:1]};
        r_next.tx_bits = r_reg.tx_bits + 1'b1;
        if (r_reg.tx_bits == boot_loader_pkg::FRAME_LAST) r_next.tx_busy = 1'b0;
      end
    end
    r_next.txd = r_next.tx_busy ? r_next.tx_shift[0] : 1'b1;
    if (got) begin
      r_next.echo_pend = 1'b1;
      r_next.echo_ch = ch;
    end
    // Record parser
    case (r_reg.ps)
      boot_loader_pkg::P_COLON: begin
        if (got && r_reg.rx_st != boot_loader_pkg::R_MEAS && ch == boot_loader_pkg::CHR_COLON) begin
          r_next.ps = boot_loader_pkg::P_HI;
          r_next.idx = '0;
          r_next.sum = '0;
        end
      end
      boot_loader_pkg::P_HI: begin
        h = hexval(ch);
        if (got) begin
          r_next.nib = h[3:0];
          r_next.ps = h[4] ? boot_loader_pkg::P_LO : boot_loader_pkg::P_COLON;
        end
      end
      boot_loader_pkg::P_LO: begin
        h = hexval(ch);
        b = {r_reg.nib, h[3:0]};
        if (got && !h[4]) begin
          r_next.ps = boot_loader_pkg::P_COLON;
        end else if (got) begin
          r_next.sum = r_reg.sum + b;
          r_next.ps = boot_loader_pkg::P_HI;
          r_next.idx = r_reg.idx + 1'b1;
          case (r_reg.idx)
            5'h00: r_next.cnt = b;
            5'h01: r_next.addr[15:8] = b;
            5'h02: r_next.addr[7:0] = b;
            5'h03: r_next.typ = b;
            default: if (8'(r_reg.idx - boot_loader_pkg::HEADER_BYTES) < r_reg.cnt)
              r_next.data[4'(r_reg.idx - boot_loader_pkg::HEADER_BYTES)] = b;
          endcase
          if (r_reg.idx == 5'h00 && b > boot_loader_pkg::MAX_DATA) begin
            r_next.ps = boot_loader_pkg::P_COLON;
            r_next.rep_pend = 1'b1;
            r_next.rep_ch = boot_loader_pkg::CHR_X;
          end else if (8'(r_reg.idx) == r_reg.cnt + 8'(boot_loader_pkg::HEADER_BYTES)) begin
            r_next.ps = boot_loader_pkg::P_EOL;
          end
        end
      end
      boot_loader_pkg::P_EOL: begin
        if (got && ch == boot_loader_pkg::CHR_LF) r_next.ps = boot_loader_pkg::P_EXEC;
      end
      boot_loader_pkg::P_EXEC: begin
        r_next.ps = boot_loader_pkg::P_COLON;
        r_next.rep_pend = 1'b1;
        r_next.rep_ch = boot_loader_pkg::CHR_DOT;
        if (r_reg.sum != 8'h00) begin
          r_next.rep_ch = boot_loader_pkg::CHR_X;
        end else begin
          case (r_reg.typ)
            boot_loader_pkg::REC_DATA: begin
              r_next.rep_pend = 1'b0;
              r_next.ps = boot_loader_pkg::P_PROG;
              r_next.push_i = '0;
              r_next.done_i = '0;
              r_next.fail = 1'b0;
            end
            boot_loader_pkg::REC_EOF: r_next.rep_ch = boot_loader_pkg::CHR_DOT;
            boot_loader_pkg::REC_OSC: r_next.osc = r_reg.data[0];
            boot_loader_pkg::REC_WRITE: begin
              r_next.cmd_valid = 1'b1;
              if (r_reg.data[0] == boot_loader_pkg::SUB_ERASE_NV) begin
                r_next.nv_write = 1'b1;
                r_next.nv_status = 8'h00;
                r_next.nv_vector = 8'h00;
              end else if (r_reg.data[0] == boot_loader_pkg::SUB_CHIP_ERASE) begin
                r_next.nv_write = 1'b1;
                r_next.nv_status = 8'h00;
                r_next.nv_vector = boot_loader_pkg::DEFAULT_VECTOR;
              end else if (r_reg.data[0] == boot_loader_pkg::SUB_PROG_NV) begin
                r_next.nv_write = 1'b1;
                r_next.nv_status = (r_reg.data[1] == 8'h00) ? r_reg.data[2] : status_byte;
                r_next.nv_vector = (r_reg.data[1] == 8'h00) ? boot_vector : r_reg.data[2];
              end
            end
            boot_loader_pkg::REC_DISPLAY: begin
              r_next.cmd_valid = 1'b1;
              r_next.rep_pend = 1'b0;
            end
            default: r_next.cmd_valid = 1'b1;
          endcase
        end
      end
      boot_loader_pkg::P_PROG: begin
        fifo_in_valid = 8'(r_reg.push_i) < r_reg.cnt;
        if (fifo_in_valid && fifo_in_ready) r_next.push_i = r_reg.push_i + 1'b1;
        if (prog_valid && prog_ready) begin
          r_next.done_i = r_reg.done_i + 1'b1;
          if (prog_fail) r_next.fail = 1'b1;
        end
        if (8'(r_reg.done_i) == r_reg.cnt) begin
          r_next.ps = boot_loader_pkg::P_COLON;
          r_next.rep_pend = 1'b1;
          r_next.rep_ch = r_reg.fail ? boot_loader_pkg::CHR_R : boot_loader_pkg::CHR_DOT;
        end
      end
      default: r_next.ps = boot_loader_pkg::P_COLON;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.txd <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign txd = r_reg.txd;
  assign start_addr = r_reg.start_addr;
  assign start_valid = r_reg.start_valid;
  assign fetch_boot_rom = r_reg.fetch_rom;
  assign fetch_block = r_reg.fetch_block;
  assign osc_mhz = r_reg.osc;
  assign nv_write = r_reg.nv_write;
  assign nv_status = r_reg.nv_status;
  assign nv_vector = r_reg.nv_vector;
  assign cmd_valid = r_reg.cmd_valid;
  assign cmd_type = r_reg.typ;
  assign cmd_sub = r_reg.data[0];
  assign cmd_sel = r_reg.data[1];
  assign baud_locked = r_reg.locked;

  function automatic logic rep_pend_chk(input logic [7:0] c);
    rep_pend_chk = r_reg.rep_pend && r_reg.rep_ch == c;
  endfunction : rep_pend_chk

  sequence seq_bad_sum;
    r_reg.ps == boot_loader_pkg::P_EXEC && r_reg.sum != 8'h00;
  endsequence
  sequence seq_prog_end;
    r_reg.ps == boot_loader_pkg::P_PROG && 8'(r_reg.done_i) == r_reg.cnt;
  endsequence

  AST_BOOT_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(start_valid) && $past(status_byte) == 8'h00 && !$past(strap_force) |-> start_addr == 16'h0000)
    else $error("zero status did not start at 0000");
  AST_BOOT_VECTOR: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(start_valid) && $past(status_byte) != 8'h00 |-> start_addr == {$past(boot_vector), 8'h00})
    else $error("nonzero status did not use vector");
  AST_BOOT_STRAP: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(start_valid) && $past(strap_force) |-> start_addr[7:0] == 8'h00 && start_addr[15:8] == $past(boot_vector))
    else $error("strap did not force loader start");
  AST_ROM_OVERLAY: assert property (@(posedge mclk) disable iff (!rst_n)
    fetch_addr >= 16'hfc00 ##1 1'b1 |-> fetch_boot_rom == $past(boot_rom_enable))
    else $error("boot rom overlay wrong");
  AST_BLOCKS: assert property (@(posedge mclk) disable iff (!rst_n)
    fetch_addr < 16'h4000 |=> fetch_block == {2'b00, $past(fetch_addr[13])})
    else $error("8 kB block decode wrong");
  AST_BAD_SUM: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_bad_sum |=> rep_pend_chk(boot_loader_pkg::CHR_X) && !nv_write && !cmd_valid ##1 !fifo_in_valid)
    else $error("bad checksum not answered with X");
  AST_PROG_RESULT: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_prog_end |=> r_reg.rep_pend && r_reg.rep_ch == ($past(r_reg.fail) ? 8'h52 : 8'h2e))
    else $error("data record reply wrong");
  AST_ECHO: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(r_reg.echo_pend) |-> ##[1:3] r_reg.tx_busy && r_reg.tx_shift[8:1] == r_reg.echo_ch)
    else $error("received character not echoed");
  AST_ERASE_BOTH: assert property (@(posedge mclk) disable iff (!rst_n)
    nv_write && $past(r_reg.data[0]) == 8'h04 |-> nv_status == 8'h00 && nv_vector == 8'h00)
    else $error("erase did not clear both bytes");
endmodule : flash_boot_loader
`default_nettype wire

// file: tb/host_uart_model.sv
// Purpose: Host programmer model on the serial link
// Assumes: 8N1 framing, fixed bit length in mclk cycles
// Notes: Each character read from txd gives a one-cycle strobe
`timescale 1ns/1ns
`default_nettype none
module host_uart_model #(parameter int BIT_CYC = 16) (
  input wire logic mclk,
  output logic rxd,
  input wire logic txd,
  output logic [7:0] rx_char,
  output logic rx_stb
);
  initial begin
    rxd = 1'b1;
    rx_char = 8'h00;
    rx_stb = 1'b0;
  end

  // One character, then two idle bit times
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk) #1 rxd = f[i];
      repeat (BIT_CYC - 1) @(posedge mclk);
    end
    repeat (2 * BIT_CYC) @(posedge mclk);
  endtask : send_char

  // Receiver samples mid-bit
  always begin
    @(negedge txd);
    repeat (BIT_CYC + BIT_CYC / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      rx_char[i] = txd;
      repeat (BIT_CYC) @(posedge mclk);
    end
    #1 rx_stb = 1'b1;
    @(posedge mclk) #1 rx_stb = 1'b0;
  end
endmodule : host_uart_model
`default_nettype wire

// file: tb/flash_boot_select_and_serial_loader_test.sv
// Purpose: Self-checking bench for boot select, decode and serial loader
// Assumes: Host bit length of 16 mclk cycles
// Notes: Expected echoes, replies and programmed bytes queue up in order
`timescale 1ns/1ns
`default_nettype none
module flash_boot_select_and_serial_loader_test;
  logic mclk = 1'b0;
  logic reset_n, rxd, txd, start_valid, boot_rom_enable, fetch_boot_rom, prog_valid, prog_ready, prog_fail;
  logic program_store_strobe_n, port2_bit7_strap, external_access_n, ale_strap, nv_write, cmd_valid, baud_locked;
  logic [7:0] status_byte, boot_vector, prog_data, osc_mhz, nv_status, nv_vector, cmd_type, cmd_sub, cmd_sel;
  logic [7:0] rx_char;
  logic rx_stb;
  logic [15:0] start_addr, fetch_addr, prog_addr, a;
  logic [2:0] fetch_block;
  logic [7:0] exp_char[$];
  logic [23:0] exp_prog[$];
  logic [15:0] exp_nv[$];
  logic [23:0] exp_cmd[$];
  logic [7:0] rs, rv;
  logic [3:0] rp;
  logic [7:0] b[$];
  logic [15:0] edge_addr[8] = '{16'h1fff, 16'h2000, 16'h3fff, 16'h4000, 16'h7fff, 16'h8000, 16'hfbff, 16'hfc00};
  int num_errors = 0;
  int samples_checked = 0;

  always #50 mclk = ~mclk;

  flash_boot_loader #(.CW(16), .DEPTH(32)) u_dut (.mclk(mclk), .reset_n(reset_n), .rxd(rxd), .txd(txd),
    .status_byte(status_byte), .boot_vector(boot_vector), .program_store_strobe_n(program_store_strobe_n),
    .port2_bit7_strap(port2_bit7_strap), .external_access_n(external_access_n), .ale_strap(ale_strap),
    .start_addr(start_addr), .start_valid(start_valid), .boot_rom_enable(boot_rom_enable),
    .fetch_addr(fetch_addr), .fetch_boot_rom(fetch_boot_rom), .fetch_block(fetch_block),
    .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_fail(prog_fail), .prog_addr(prog_addr),
    .prog_data(prog_data), .osc_mhz(osc_mhz), .nv_write(nv_write), .nv_status(nv_status),
    .nv_vector(nv_vector), .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_sub(cmd_sub),
    .cmd_sel(cmd_sel), .baud_locked(baud_locked));

  host_uart_model #(.BIT_CYC(16)) u_host (.mclk(mclk), .rxd(rxd), .txd(txd), .rx_char(rx_char),
    .rx_stb(rx_stb));

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // Result watchers
  always @(posedge mclk) begin
    if (rx_stb === 1'b1) chk({16'h0, rx_char}, {16'h0, exp_char.size() ? exp_char.pop_front() : 8'hxx});
    if (prog_valid === 1'b1 && prog_ready) chk({prog_addr, prog_data}, exp_prog.size() ? exp_prog.pop_front() : 'x);
    if (nv_write === 1'b1) chk({8'h0, nv_status, nv_vector}, {8'h0, exp_nv.size() ? exp_nv.pop_front() : 16'hxxxx});
    if (cmd_valid === 1'b1) chk({cmd_type, cmd_sub, cmd_sel}, exp_cmd.size() ? exp_cmd.pop_front() : 'x);
  end

  // Programmer stalls at random
  always @(posedge mclk) #1 prog_ready = 1'($urandom);

  task automatic boot_case(input logic [7:0] st, input logic [7:0] vec, input logic [3:0] straps, input logic [15:0] exp);
    reset_n = 1'b0;
    status_byte = st;
    boot_vector = vec;
    {program_store_strobe_n, port2_bit7_strap, external_access_n, ale_strap} = straps;
    repeat (5) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk({7'h0, start_valid, start_addr}, {8'h01, exp});
  endtask : boot_case

  // Hex record with checksum, CR LF, reply, then drain
  task automatic send_rec(input logic bad, input logic [7:0] reply);
    logic [7:0] s;
    string t;
    s = 8'h00;
    foreach (b[i]) s += b[i];
    b.push_back(8'h00 - s + {7'h00, bad});
    t = ":";
    foreach (b[i]) t = {t, $sformatf("%02X", b[i])};
    for (int i = 0; i < t.len(); i++) begin
      exp_char.push_back(t[i]);
      u_host.send_char(t[i]);
    end
    exp_char.push_back(8'h0d);
    u_host.send_char(8'h0d);
    exp_char.push_back(8'h0a);
    u_host.send_char(8'h0a);
    exp_char.push_back(reply);
    for (int n = 0; n < 8000 && (exp_char.size() > 0 || exp_prog.size() > 0); n++) @(posedge mclk);
    if (exp_char.size() > 0 || exp_prog.size() > 0) begin
      num_errors++;
      results();
    end
  endtask : send_rec

  task automatic data_rec(input int cnt, input logic bad, input logic fail, input logic [7:0] reply);
    logic [7:0] d;
    a = 16'h4000 + 16'($urandom & 32'h0fff);
    @(posedge mclk) #1 prog_fail = fail;
    b = '{8'(cnt), a[15:8], a[7:0], 8'h00};
    for (int i = 0; i < cnt; i++) begin
      d = 8'($urandom);
      b.push_back(d);
      if (!bad) exp_prog.push_back({a + 16'(i), d});
    end
    send_rec(bad, reply);
  endtask : data_rec

  initial begin
    void'($urandom(32'h4680));
    reset_n = 1'b0;
    prog_fail = 1'b0;
    boot_rom_enable = 1'b0;
    fetch_addr = 16'h0000;
    boot_case(8'h00, boot_loader_pkg::DEFAULT_VECTOR, 4'b1000, 16'h0000);
    boot_case(8'h5a, boot_loader_pkg::DEFAULT_VECTOR, 4'b1000, 16'hfc00);
    boot_case(8'h00, 8'h80, 4'b0111, 16'h8000);
    boot_case(8'h01, 8'h12, 4'b1000, 16'h1200);
    for (int i = 0; i < 6; i++) begin
      rs = 8'($urandom & 32'h3);
      rv = 8'($urandom);
      rp = 1'($urandom) ? 4'b0111 : 4'($urandom);
      boot_case(rs, rv, rp, (rs == 8'h00 && rp != 4'b0111) ? 16'h0000 : {rv, 8'h00});
    end
    for (int i = 0; i < 40; i++) begin
      a = (i < 8) ? edge_addr[i] : 16'($urandom);
      @(posedge mclk) #1 fetch_addr = a;
      boot_rom_enable = 1'($urandom);
      @(posedge mclk) #1 chk({20'h0, fetch_boot_rom, fetch_block}, {20'h0, boot_rom_enable && a >= 16'hfc00,
        (a < 16'h4000) ? {2'b00, a[13]} : {1'b0, a[15:14]} + 3'h1});
    end
    exp_char.push_back(boot_loader_pkg::CHR_U);
    u_host.send_char(boot_loader_pkg::CHR_U);
    chk({23'h0, baud_locked}, 24'h1);
    b = '{8'h01, 8'h00, 8'h00, 8'h02, 8'h0a};
    send_rec(1'b0, boot_loader_pkg::CHR_DOT);
    chk({16'h0, osc_mhz}, 24'h00000a);
    data_rec(16, 1'b0, 1'b0, boot_loader_pkg::CHR_DOT);
    data_rec(2, 1'b0, 1'b1, boot_loader_pkg::CHR_R);
    data_rec(3, 1'b1, 1'b0, boot_loader_pkg::CHR_X);
    exp_nv.push_back(16'h0000);
    exp_cmd.push_back(24'h030400);
    b = '{8'h02, 8'h00, 8'h00, 8'h03, 8'h04, 8'h00};
    send_rec(1'b0, boot_loader_pkg::CHR_DOT);
    exp_nv.push_back({8'h00, boot_loader_pkg::DEFAULT_VECTOR});
    exp_cmd.push_back(24'h030700);
    b = '{8'h02, 8'h00, 8'h00, 8'h03, 8'h07, 8'h00};
    send_rec(1'b0, boot_loader_pkg::CHR_DOT);
    exp_nv.push_back({8'h00, boot_vector});
    exp_cmd.push_back(24'h030600);
    b = '{8'h03, 8'h00, 8'h00, 8'h03, 8'h06, 8'h00, 8'h00};
    send_rec(1'b0, boot_loader_pkg::CHR_DOT);
    chk({8'h0, 16'(exp_nv.size() + exp_cmd.size())}, 24'h0);
    b = '{8'h00, 8'h00, 8'h00, 8'h01};
    send_rec(1'b0, boot_loader_pkg::CHR_DOT);
    results();
  end

  initial begin
    repeat (90000) @(posedge mclk);
    num_errors++;
    results();
  end
endmodule : flash_boot_select_and_serial_loader_test
`default_nettype wire
